/* File: dv/agc_time_programming_test.sv */
// Self-checking bench for the AGC time programming registers
`timescale 1ns/100ps
module agc_time_programming_test;
  import agc_time_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 7'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [TIME_W-1:0] legacy_left_decay_ms = 16'h1234;
  logic [TIME_W-1:0] legacy_right_attack_ms = 16'h0abc;
  logic [RATIO_W-1:0] adc_clock_divide_ratio = 4'hf;
  logic [TIME_W-1:0] left_decay_ms;
  logic [TIME_W-1:0] right_attack_ms;
  logic [TIME_W-1:0] dec_base [4] = '{16'h0032, 16'h0096, 16'h00fa, 16'h015e};
  logic [TIME_W-1:0] atk_base [4] = '{16'h0007, 16'h0008, 16'h000a, 16'h000b};
  int failures = 0;
  int checks_done = 0;
  int e;

  agc_time_programming dut_u (.clock(clock), .reset(reset), .clock_en(clock_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .legacy_left_decay_ms(legacy_left_decay_ms),
    .legacy_right_attack_ms(legacy_right_attack_ms),
    .adc_clock_divide_ratio(adc_clock_divide_ratio), .left_decay_ms(left_decay_ms),
    .right_attack_ms(right_attack_ms));

  always #5 clock = ~clock;

  function automatic int ceil_ms(input logic [RATIO_W-1:0] r);
    case (r)
      4'h0: ceil_ms = 4000;
      4'h1: ceil_ms = 5600;
      4'h2: ceil_ms = 8000;
      4'h3: ceil_ms = 9600;
      4'h4, 4'h5: ceil_ms = 11200;
      4'h6, 4'h7: ceil_ms = 16000;
      4'h8: ceil_ms = 19200;
      default: ceil_ms = 22400;
    endcase
  endfunction

  task automatic check(input string name, input logic [TIME_W-1:0] seen,
                       input logic [TIME_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Called at a falling edge; returns one falling edge after the strobe drops
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    @(negedge clock);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    finish_test;
  end

  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check("left_decay_ms", left_decay_ms, 16'h1234);
    check("right_attack_ms", right_attack_ms, 16'h0abc);
    rd(LEFT_DECAY_ADDR, REG_RESET);
    rd(RIGHT_ATTACK_ADDR, REG_RESET);
    legacy_left_decay_ms = 16'h4321;
    legacy_right_attack_ms = 16'h0123;
    @(negedge clock);
    check("left_decay_ms", left_decay_ms, 16'h4321);
    check("right_attack_ms", right_attack_ms, 16'h0123);
    $display("test reset and legacy done");
    wr(LEFT_DECAY_ADDR, 8'h7c);
    check("left_decay_ms", left_decay_ms, 16'h4321);
    wr(RIGHT_ATTACK_ADDR, 8'h7c);
    check("right_attack_ms", right_attack_ms, 16'h0123);
    rd(LEFT_DECAY_ADDR, 8'h7c);
    rd(7'h6a, UNMAPPED_READ);
    wr(7'h6a, 8'hff);
    rd(RIGHT_ATTACK_ADDR, 8'h7c);
    $display("test readback done");
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        wr(RIGHT_ATTACK_ADDR, {1'b1, 2'(b), 3'(m), 2'b00});
        check("right_attack_ms", right_attack_ms, atk_base[b] << m);
        wr(LEFT_DECAY_ADDR, {1'b1, 2'(b), 3'(m), 2'b00});
        e = int'(dec_base[b]) << m;
        if (e > 22400) e = 22400;
        check("left_decay_ms", left_decay_ms, TIME_W'(e));
      end
    end
    rd(LEFT_DECAY_ADDR, 8'hfc);
    $display("test field sweep done");
    for (int r = 0; r < 16; r++) begin
      adc_clock_divide_ratio = 4'(r);
      @(negedge clock);
      check("left_decay_ms", left_decay_ms, TIME_W'(ceil_ms(4'(r))));
    end
    adc_clock_divide_ratio = 4'h0;
    wr(LEFT_DECAY_ADDR, 8'hd8);
    check("left_decay_ms", left_decay_ms, 16'h0fa0);
    adc_clock_divide_ratio = 4'h4;
    @(negedge clock);
    check("left_decay_ms", left_decay_ms, 16'h2bc0);
    wr(LEFT_DECAY_ADDR, 8'h7c);
    legacy_left_decay_ms = 16'h9000;
    @(negedge clock);
    check("left_decay_ms", left_decay_ms, 16'h9000);
    $display("test ceiling done");
    clock_en = 1'b0;
    wr(RIGHT_ATTACK_ADDR, 8'h80);
    legacy_left_decay_ms = 16'h0055;
    @(negedge clock);
    check("left_decay_ms", left_decay_ms, 16'h9000);
    clock_en = 1'b1;
    rd(RIGHT_ATTACK_ADDR, 8'hfc);
    check("left_decay_ms", left_decay_ms, 16'h0055);
    $display("test clock enable done");
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    rd(LEFT_DECAY_ADDR, REG_RESET);
    rd(RIGHT_ATTACK_ADDR, REG_RESET);
    check("right_attack_ms", right_attack_ms, 16'h0123);
    $display("test second reset done");
    finish_test;
  end
endmodule // agc_time_programming_test

/* File: hdl/agc_time_calc.sv */
// Effective AGC time from one programming register and its legacy time
`timescale 1ns/100ps
module agc_time_calc
  import agc_time_pkg::*;
#(
  parameter bit IS_DECAY = 1'b1
) (
  input wire logic [DATA_W-1:0] ctrl,
  input wire logic [TIME_W-1:0] legacy_ms,
  input wire logic [RATIO_W-1:0] adc_clock_divide_ratio,
  output logic [TIME_W-1:0] time_ms
);
  logic [TIME_W-1:0] base_ms;
  logic [TIME_W-1:0] prog_ms;
  logic [TIME_W-1:0] ceil_ms;

  always_comb begin
    base_ms = IS_DECAY ? decay_base_ms(ctrl[BASE_HI:BASE_LO])
                       : attack_base_ms(ctrl[BASE_HI:BASE_LO]);
    prog_ms = scale_ms(base_ms, ctrl[MULT_HI:MULT_LO]);
    ceil_ms = decay_ceiling_ms(adc_clock_divide_ratio);
    if (IS_DECAY && prog_ms > ceil_ms) begin
      prog_ms = ceil_ms;
    end
    time_ms = ctrl[SEL_BIT] ? prog_ms : legacy_ms;
  end
endmodule // agc_time_calc

/* File: hdl/agc_time_pkg.sv */
// Constants, lookups and field layout for the AGC time programming registers
package agc_time_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int TIME_W = 16;
  localparam int RATIO_W = 4;

  localparam logic [ADDR_W-1:0] LEFT_DECAY_ADDR = 7'h68;
  localparam logic [ADDR_W-1:0] RIGHT_ATTACK_ADDR = 7'h69;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  localparam int SEL_BIT = 7;
  localparam int BASE_HI = 6;
  localparam int BASE_LO = 5;
  localparam int MULT_HI = 4;
  localparam int MULT_LO = 2;

  localparam logic [TIME_W-1:0] DECAY_BASE_0_MS = 16'h0032; // 50 ms
  localparam logic [TIME_W-1:0] DECAY_BASE_1_MS = 16'h0096; // 150 ms
  localparam logic [TIME_W-1:0] DECAY_BASE_2_MS = 16'h00fa; // 250 ms
  localparam logic [TIME_W-1:0] DECAY_BASE_3_MS = 16'h015e; // 350 ms
  localparam logic [TIME_W-1:0] ATTACK_BASE_0_MS = 16'h0007; // 7 ms
  localparam logic [TIME_W-1:0] ATTACK_BASE_1_MS = 16'h0008; // 8 ms
  localparam logic [TIME_W-1:0] ATTACK_BASE_2_MS = 16'h000a; // 10 ms
  localparam logic [TIME_W-1:0] ATTACK_BASE_3_MS = 16'h000b; // 11 ms

  // Divide ratio nibble: code n means ratio 1 + n/2
  localparam logic [RATIO_W-1:0] RATIO_1 = 4'h0;
  localparam logic [RATIO_W-1:0] RATIO_1P5 = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_2 = 4'h2;
  localparam logic [RATIO_W-1:0] RATIO_2P5 = 4'h3;
  localparam logic [RATIO_W-1:0] RATIO_3 = 4'h4;
  localparam logic [RATIO_W-1:0] RATIO_3P5 = 4'h5;
  localparam logic [RATIO_W-1:0] RATIO_4 = 4'h6;
  localparam logic [RATIO_W-1:0] RATIO_4P5 = 4'h7;
  localparam logic [RATIO_W-1:0] RATIO_5 = 4'h8;
  localparam logic [TIME_W-1:0] CEIL_4S_MS = 16'h0fa0;
  localparam logic [TIME_W-1:0] CEIL_5P6S_MS = 16'h15e0;
  localparam logic [TIME_W-1:0] CEIL_8S_MS = 16'h1f40;
  localparam logic [TIME_W-1:0] CEIL_9P6S_MS = 16'h2580;
  localparam logic [TIME_W-1:0] CEIL_11P2S_MS = 16'h2bc0;
  localparam logic [TIME_W-1:0] CEIL_16S_MS = 16'h3e80;
  localparam logic [TIME_W-1:0] CEIL_19P2S_MS = 16'h4b00;
  localparam logic [TIME_W-1:0] CEIL_22P4S_MS = 16'h5780;

  function automatic logic [TIME_W-1:0] decay_base_ms(input logic [1:0] code);
    case (code)
      2'h0: decay_base_ms = DECAY_BASE_0_MS;
      2'h1: decay_base_ms = DECAY_BASE_1_MS;
      2'h2: decay_base_ms = DECAY_BASE_2_MS;
      default: decay_base_ms = DECAY_BASE_3_MS;
    endcase
  endfunction

  function automatic logic [TIME_W-1:0] attack_base_ms(input logic [1:0] code);
    case (code)
      2'h0: attack_base_ms = ATTACK_BASE_0_MS;
      2'h1: attack_base_ms = ATTACK_BASE_1_MS;
      2'h2: attack_base_ms = ATTACK_BASE_2_MS;
      default: attack_base_ms = ATTACK_BASE_3_MS;
    endcase
  endfunction

  function automatic logic [TIME_W-1:0] scale_ms(input logic [TIME_W-1:0] base,
                                                 input logic [2:0] mult);
    scale_ms = base << mult;
  endfunction

  // Reserved ratio codes take the largest ceiling
  function automatic logic [TIME_W-1:0] decay_ceiling_ms(input logic [RATIO_W-1:0] ratio);
    case (ratio)
      RATIO_1: decay_ceiling_ms = CEIL_4S_MS;
      RATIO_1P5: decay_ceiling_ms = CEIL_5P6S_MS;
      RATIO_2: decay_ceiling_ms = CEIL_8S_MS;
      RATIO_2P5: decay_ceiling_ms = CEIL_9P6S_MS;
      RATIO_3, RATIO_3P5: decay_ceiling_ms = CEIL_11P2S_MS;
      RATIO_4, RATIO_4P5: decay_ceiling_ms = CEIL_16S_MS;
      RATIO_5: decay_ceiling_ms = CEIL_19P2S_MS;
      default: decay_ceiling_ms = CEIL_22P4S_MS;
    endcase
  endfunction
endpackage

/* File: hdl/agc_time_programming.sv */
// Left decay and right attack AGC time registers with effective time outputs
`timescale 1ns/100ps
module agc_time_programming
  import agc_time_pkg::*;
#(
  parameter int TIME_BITS = TIME_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [TIME_W-1:0] legacy_left_decay_ms,
  input wire logic [TIME_W-1:0] legacy_right_attack_ms,
  input wire logic [RATIO_W-1:0] adc_clock_divide_ratio,
  output logic [TIME_W-1:0] left_decay_ms,
  output logic [TIME_W-1:0] right_attack_ms
);
  generate
    if (TIME_BITS != TIME_W) begin : g_bad_width
      $error("TIME_BITS must equal the package time width");
    end
  endgenerate

  logic [DATA_W-1:0] left_r, left_nxt;
  logic [DATA_W-1:0] right_r, right_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [TIME_W-1:0] left_ms_r, left_ms_nxt;
  logic [TIME_W-1:0] right_ms_r, right_ms_nxt;
  logic [TIME_W-1:0] left_calc;
  logic [TIME_W-1:0] right_calc;

  agc_time_calc #(.IS_DECAY(1'b1)) u_left_decay (
    .ctrl(left_r),
    .legacy_ms(legacy_left_decay_ms),
    .adc_clock_divide_ratio(adc_clock_divide_ratio),
    .time_ms(left_calc)
  );

  agc_time_calc #(.IS_DECAY(1'b0)) u_right_attack (
    .ctrl(right_r),
    .legacy_ms(legacy_right_attack_ms),
    .adc_clock_divide_ratio(adc_clock_divide_ratio),
    .time_ms(right_calc)
  );

  always_comb begin
    left_nxt = left_r;
    right_nxt = right_r;
    rdata_nxt = rdata_r;
    left_ms_nxt = left_calc;
    right_ms_nxt = right_calc;
    if (reg_wr) begin
      // All eight bits stored; bits 1 and 0 read back as written
      if (reg_addr == LEFT_DECAY_ADDR) begin
        left_nxt = reg_wdata;
      end
      if (reg_addr == RIGHT_ATTACK_ADDR) begin
        right_nxt = reg_wdata;
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        LEFT_DECAY_ADDR: rdata_nxt = left_r;
        RIGHT_ATTACK_ADDR: rdata_nxt = right_r;
        default: rdata_nxt = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      left_r <= REG_RESET;
      right_r <= REG_RESET;
      rdata_r <= REG_RESET;
      left_ms_r <= '0;
      right_ms_r <= '0;
    end else if (clock_en) begin
      left_r <= left_nxt;
      right_r <= right_nxt;
      rdata_r <= rdata_nxt;
      left_ms_r <= left_ms_nxt;
      right_ms_r <= right_ms_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign left_decay_ms = left_ms_r;
  assign right_attack_ms = right_ms_r;

  // Write sequences used by the baseline checks
  sequence s_left_150_write;
    clock_en && reg_wr && reg_addr == LEFT_DECAY_ADDR && reg_wdata == 8'ha0;
  endsequence

  sequence s_right_11_write;
    clock_en && reg_wr && reg_addr == RIGHT_ATTACK_ADDR && reg_wdata == 8'he0;
  endsequence

  property p_reset_zero;
    @(posedge clock) $fell(reset) |-> left_r == REG_RESET && right_r == REG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

  property p_left_legacy;
    @(posedge clock) disable iff (reset)
      clock_en && !left_r[SEL_BIT] |=> left_decay_ms == $past(legacy_left_decay_ms);
  endproperty
  a_left_legacy: assert property (p_left_legacy) else $error("left decay not legacy");

  property p_left_base;
    @(posedge clock) disable iff (reset)
      s_left_150_write ##1 clock_en |=> left_decay_ms == DECAY_BASE_1_MS;
  endproperty
  a_left_base: assert property (p_left_base) else $error("left baseline wrong");

  property p_left_scaled;
    @(posedge clock) disable iff (reset)
      clock_en && left_r[SEL_BIT] && scale_ms(decay_base_ms(left_r[BASE_HI:BASE_LO]),
        left_r[MULT_HI:MULT_LO]) <= decay_ceiling_ms(adc_clock_divide_ratio)
      |=> left_decay_ms == scale_ms(decay_base_ms($past(left_r[BASE_HI:BASE_LO])),
        $past(left_r[MULT_HI:MULT_LO]));
  endproperty
  a_left_scaled: assert property (p_left_scaled) else $error("left decay scale wrong");

  property p_right_product;
    @(posedge clock) disable iff (reset)
      clock_en && right_r[SEL_BIT] |=> right_attack_ms ==
        scale_ms(attack_base_ms($past(right_r[BASE_HI:BASE_LO])),
        $past(right_r[MULT_HI:MULT_LO]));
  endproperty
  a_right_product: assert property (p_right_product) else $error("attack product wrong");

  property p_left_ceiling;
    @(posedge clock) disable iff (reset)
      clock_en && left_r[SEL_BIT] |=>
        left_decay_ms <= decay_ceiling_ms($past(adc_clock_divide_ratio));
  endproperty
  a_left_ceiling: assert property (p_left_ceiling) else $error("decay above ceiling");

  property p_right_legacy;
    @(posedge clock) disable iff (reset)
      clock_en && !right_r[SEL_BIT] |=> right_attack_ms == $past(legacy_right_attack_ms);
  endproperty
  a_right_legacy: assert property (p_right_legacy) else $error("right attack not legacy");

  property p_right_base;
    @(posedge clock) disable iff (reset)
      s_right_11_write ##1 clock_en |=> right_attack_ms == ATTACK_BASE_3_MS;
  endproperty
  a_right_base: assert property (p_right_base) else $error("right baseline wrong");

  property p_right_max_mult;
    @(posedge clock) disable iff (reset)
      clock_en && right_r[SEL_BIT] && right_r[MULT_HI:MULT_LO] == 3'h7 |=>
        right_attack_ms == (attack_base_ms($past(right_r[BASE_HI:BASE_LO])) << 7);
  endproperty
  a_right_max_mult: assert property (p_right_max_mult) else $error("attack x128 wrong");

  // Register port steps shared by the read checks
  sequence s_left_read;
    clock_en && reg_rd && reg_addr == LEFT_DECAY_ADDR;
  endsequence

  sequence s_right_read;
    clock_en && reg_rd && reg_addr == RIGHT_ATTACK_ADDR;
  endsequence

  property p_left_read;
    @(posedge clock) disable iff (reset)
      s_left_read |=> reg_rdata == $past(left_r);
  endproperty
  a_left_read: assert property (p_left_read) else $error("left readback wrong");

  property p_right_read;
    @(posedge clock) disable iff (reset)
      s_right_read |=> reg_rdata == $past(right_r);
  endproperty
  a_right_read: assert property (p_right_read) else $error("right readback wrong");

  property p_unmapped_read;
    @(posedge clock) disable iff (reset)
      clock_en && reg_rd && reg_addr != LEFT_DECAY_ADDR && reg_addr != RIGHT_ATTACK_ADDR
      |=> reg_rdata == UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_left_write;
    @(posedge clock) disable iff (reset)
      clock_en && reg_wr && reg_addr == LEFT_DECAY_ADDR |=> left_r == $past(reg_wdata);
  endproperty
  a_left_write: assert property (p_left_write) else $error("left write lost");

  property p_right_write;
    @(posedge clock) disable iff (reset)
      clock_en && reg_wr && reg_addr == RIGHT_ATTACK_ADDR |=> right_r == $past(reg_wdata);
  endproperty
  a_right_write: assert property (p_right_write) else $error("right write lost");

  property p_hold_disabled;
    @(posedge clock) disable iff (reset)
      !clock_en |=> $stable(left_r) && $stable(right_r) && $stable(reg_rdata) &&
        $stable(left_decay_ms) && $stable(right_attack_ms);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("state moved while disabled");

  property p_reset_outputs;
    @(posedge clock) reset |=> left_decay_ms == '0 && right_attack_ms == '0 &&
      reg_rdata == REG_RESET;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared");

  property p_left_clamped;
    @(posedge clock) disable iff (reset)
      clock_en && left_r[SEL_BIT] && scale_ms(decay_base_ms(left_r[BASE_HI:BASE_LO]),
        left_r[MULT_HI:MULT_LO]) > decay_ceiling_ms(adc_clock_divide_ratio)
      |=> left_decay_ms == decay_ceiling_ms($past(adc_clock_divide_ratio));
  endproperty
  a_left_clamped: assert property (p_left_clamped) else $error("decay not clamped");

  property p_read_holds;
    @(posedge clock) disable iff (reset)
      clock_en && !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_read_holds: assert property (p_read_holds) else $error("read data moved without read");
endmodule // agc_time_programming
